/* File: comp_channel.sv */
// comparator package plus one comparator channel: sync, edge detect, event pulses
// assumes the raw comparator output is asynchronous to aclk
`default_nettype none

package comp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MIS    = 8'h00;
  localparam logic [7:0] OFS_RIS    = 8'h04;
  localparam logic [7:0] OFS_INTEN  = 8'h08;
  localparam logic [7:0] OFS_REFCTL = 8'h10;
  localparam logic [7:0] OFS_STAT0  = 8'h20;
  localparam logic [7:0] OFS_CTL0   = 8'h24;
  localparam logic [7:0] OFS_STAT1  = 8'h40;
  localparam logic [7:0] OFS_CTL1   = 8'h44;
  localparam int         NUM_CHAN   = 2;
  // control word fields
  localparam int CTL_INV   = 1;
  localparam int CTL_ISEN  = 2;
  localparam int CTL_ISLV  = 4;
  localparam int CTL_TSEN  = 5;
  localparam int CTL_TSLV  = 7;
  localparam int CTL_SRC   = 9;
  localparam int CTL_TEN   = 11;
  localparam int CTL_OEN   = 12;
  localparam int STAT_VAL  = 1;
  localparam int REF_LVL   = 0;
  localparam int REF_RNG   = 8;
  localparam int REF_EN    = 9;
  // sense codes
  localparam logic [1:0] SENSE_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_FALL  = 2'h1;
  localparam logic [1:0] SENSE_RISE  = 2'h2;
  localparam logic [1:0] SENSE_BOTH  = 2'h3;
  // positive source codes
  localparam logic [1:0] SRC_CODE_A  = 2'h0;
  localparam logic [1:0] SRC_CODE_B  = 2'h1;
  localparam logic [1:0] SRC_CODE_R  = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {SRC_NONE, SRC_OWN_POS, SRC_SHARED_PIN, SRC_ZERO_POS, SRC_REF}
    pos_src_type;

  typedef struct packed {
    logic       pin_oe;
    logic       trig_en;
    logic [1:0] src;
    logic       trig_lvl;
    logic [1:0] trig_sense;
    logic       irq_lvl;
    logic [1:0] irq_sense;
    logic       invert;
  } chan_ctl_type;

  typedef struct packed {
    logic       en;
    logic       rng;
    logic [3:0] level;
  } ref_ctl_type;

  function automatic chan_ctl_type ctl_unpack(input logic [31:0] w);
    chan_ctl_type c;
    c.pin_oe     = w[CTL_OEN];
    c.trig_en    = w[CTL_TEN];
    c.src        = w[CTL_SRC +: 2];
    c.trig_lvl   = w[CTL_TSLV];
    c.trig_sense = w[CTL_TSEN +: 2];
    c.irq_lvl    = w[CTL_ISLV];
    c.irq_sense  = w[CTL_ISEN +: 2];
    c.invert     = w[CTL_INV];
    return c;
  endfunction

  function automatic logic [31:0] ctl_pack(input chan_ctl_type c);
    logic [31:0] w;
    w                 = '0;
    w[CTL_OEN]        = c.pin_oe;
    w[CTL_TEN]        = c.trig_en;
    w[CTL_SRC +: 2]   = c.src;
    w[CTL_TSLV]       = c.trig_lvl;
    w[CTL_TSEN +: 2]  = c.trig_sense;
    w[CTL_ISLV]       = c.irq_lvl;
    w[CTL_ISEN +: 2]  = c.irq_sense;
    w[CTL_INV]        = c.invert;
    return w;
  endfunction
endpackage

module comp_channel
  import comp_pkg::*;
(
  // clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // analog side and control
  input  wire logic   raw_result,
  input  wire chan_ctl_type ctl,
  // results
  output logic        value,
  output logic        irq_event,
  output logic        trig_event
);
  logic s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  logic irq_d, irq_q, trig_d, trig_q;

  // shared by irq and trigger paths, each with its own sense settings
  function automatic logic sense_hit(input logic [1:0] sense, input logic lvl,
                                     input logic prev, input logic cur);
    unique case (sense)
      SENSE_LEVEL: return cur == lvl;
      SENSE_FALL:  return prev && !cur;
      SENSE_RISE:  return !prev && cur;
      SENSE_BOTH:  return prev != cur;
    endcase
  endfunction

  always_comb
  begin
    s1_d   = raw_result;
    s2_d   = s1_q;
    s3_d   = s2_q;
    // RULE12 edges are taken from the second and third stage only
    irq_d  = sense_hit(ctl.irq_sense, ctl.irq_lvl, s3_q, s2_q); // RULE3
    trig_d = ctl.trig_en && sense_hit(ctl.trig_sense, ctl.trig_lvl, s3_q, s2_q); // RULE3
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      irq_q  <= 1'b0;
      trig_q <= 1'b0;
    end
    else
    begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      irq_q  <= irq_d;
      trig_q <= trig_d;
    end
  end

  // 1 means negative input below positive input, passed uninverted
  assign value      = s2_q; // RULE1
  assign irq_event  = irq_q;
  assign trig_event = trig_q;
endmodule

`default_nettype wire

/* File: comp_ctrl.sv */
// top of the dual comparator control: AXI4-Lite registers, source select, pin, triggers
// assumes the analog comparators, source muxes and reference ladder sit outside
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`default_nettype none

// Summary of operation
// RULE1: result is 1 when negative input is below positive input, else 0.
// RULE2: two independent channels, each with own source, status and events.
// RULE3: interrupt and ADC trigger events use separate sense settings per channel.
// RULE4: channel 0 codes 00/01 pick own positive pin, 10 the reference, 11 reserved.
// RULE5: channel 1 codes 00 shared pin, 01 channel 0 positive pin, 10 reference.
// RULE6: negative input is always the channel's own negative pin.
// RULE7: only channel 0 can drive a result pin; channel 1 has none.
// RULE8: the shared pin serves as output or channel 1 input, never both; not enforced here, left to software.
// RULE9: results also drive the pin and ADC triggers besides interrupts.
// RULE10: masked status, raw status and enable registers; one reference control.
// RULE11: writing 1 to a masked status bit clears that pending interrupt.
// RULE12: results are synchronised first; masked status is raw AND enable.
module comp_ctrl
  import comp_pkg::*;
(
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [7:0]    awaddr,
  input  wire logic          wvalid,
  output logic               wready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  output logic               bvalid,
  input  wire logic          bready,
  output logic [1:0]         bresp,
  // AXI4-Lite read
  input  wire logic          arvalid,
  output logic               arready,
  input  wire logic [7:0]    araddr,
  output logic               rvalid,
  input  wire logic          rready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  // analog side
  input  wire logic [1:0]    compare_result,
  output pos_src_type        positive_source_select [NUM_CHAN],
  output ref_ctl_type        reference_control_reg,
  // pins, triggers, interrupt
  output logic               comp_zero_out_pin,
  output logic               comp_zero_out_oe,
  output logic [1:0]         adc_trigger,
  output logic               irq
);
  chan_ctl_type ctl_q [NUM_CHAN];
  chan_ctl_type ctl_d [NUM_CHAN];
  pos_src_type  sel_q [NUM_CHAN];
  pos_src_type  sel_d [NUM_CHAN];
  ref_ctl_type  ref_q, ref_d;
  logic [1:0]   ris_q, ris_d, inten_q, inten_d;
  logic [1:0]   val, irq_ev, trig_ev;
  logic         irq_q, irq_d, pin_q, pin_d, oe_q, oe_d;
  logic [1:0]   trig_q, trig_d;
  logic         awrdy_q, awrdy_d, bvalid_q, bvalid_d, arrdy_q, arrdy_d, rvalid_q, rvalid_d;
  logic [1:0]   bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]  rdata_q, rdata_d, wmask, rword;
  logic         wr_go, rd_go, rd_hit, wr_hit;

  // two independent channels
  for (genvar i = 0; i < NUM_CHAN; i++)
  begin : g_chan
    comp_channel u_chan (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .raw_result (compare_result[i]),
      .ctl        (ctl_q[i]),
      .value      (val[i]),
      .irq_event  (irq_ev[i]),
      .trig_event (trig_ev[i])
    ); // RULE2
  end

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++)
      m[b*8 +: 8] = {8{s[b]}};
    return m;
  endfunction

  // address decode for the unmapped-address answer on both reads and writes
  function automatic logic reg_known(input logic [7:0] a);
    return a == OFS_MIS || a == OFS_RIS || a == OFS_INTEN || a == OFS_REFCTL ||
           a == OFS_STAT0 || a == OFS_CTL0 || a == OFS_STAT1 || a == OFS_CTL1;
  endfunction

  function automatic pos_src_type decode_src(input int ch, input logic [1:0] code);
    // negative input has no select path: always the channel's own pin (RULE6)
    if (code == SRC_CODE_R)
      return SRC_REF; // RULE4
    if (ch == 0)
      return (code == SRC_CODE_A || code == SRC_CODE_B) ? SRC_OWN_POS : SRC_NONE; // RULE4
    if (code == SRC_CODE_A)
      return SRC_SHARED_PIN; // RULE5
    if (code == SRC_CODE_B)
      return SRC_ZERO_POS; // RULE5
    return SRC_NONE;
  endfunction

  // bus handshakes: address and data are taken together, one cycle of ready
  always_comb
  begin
    wr_go    = awrdy_q && awvalid && wvalid;
    rd_go    = arrdy_q && arvalid;
    wr_hit   = reg_known(awaddr);
    rd_hit   = reg_known(araddr);
    wmask    = strb_mask(wstrb);
    awrdy_d  = awvalid && wvalid && !awrdy_q && !bvalid_q;
    arrdy_d  = arvalid && !arrdy_q && !rvalid_q;
    bvalid_d = wr_go || (bvalid_q && !bready);
    bresp_d  = wr_go ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_q;
    rvalid_d = rd_go || (rvalid_q && !rready);
    rresp_d  = rd_go ? (rd_hit ? RESP_OKAY : RESP_SLVERR) : rresp_q;
    rword    = '0;
    unique case (araddr)
      OFS_MIS:    rword[1:0] = ris_q & inten_q; // RULE12
      OFS_RIS:    rword[1:0] = ris_q;
      OFS_INTEN:  rword[1:0] = inten_q;
      OFS_REFCTL:
      begin
        rword[REF_EN]          = ref_q.en;
        rword[REF_RNG]         = ref_q.rng;
        rword[REF_LVL +: 4]    = ref_q.level;
      end
      OFS_STAT0:  rword[STAT_VAL] = val[0]; // RULE1
      OFS_CTL0:   rword = ctl_pack(ctl_q[0]);
      OFS_STAT1:  rword[STAT_VAL] = val[1];
      OFS_CTL1:   rword = ctl_pack(ctl_q[1]);
      default:    rword = '0;
    endcase
    rdata_d  = rd_go ? rword : rdata_q;
  end

  // register file, status, interrupt and pin outputs
  always_comb
  begin
    ctl_d   = ctl_q;
    ref_d   = ref_q;
    inten_d = inten_q;
    ris_d   = ris_q;
    if (wr_go)
    begin
      unique case (awaddr)
        OFS_MIS:    ris_d = ris_q & ~(wdata[1:0] & wmask[1:0] & inten_q); // RULE11
        OFS_INTEN:  inten_d = (inten_q & ~wmask[1:0]) | (wdata[1:0] & wmask[1:0]); // RULE10
        OFS_REFCTL: ref_d = {(wmask[REF_EN]  ? wdata[REF_EN]  : ref_q.en),
                             (wmask[REF_RNG] ? wdata[REF_RNG] : ref_q.rng),
                             (wmask[REF_LVL] ? wdata[REF_LVL +: 4] : ref_q.level)}; // RULE10
        OFS_CTL0:   ctl_d[0] = ctl_unpack((ctl_pack(ctl_q[0]) & ~wmask) | (wdata & wmask));
        OFS_CTL1:   ctl_d[1] = ctl_unpack((ctl_pack(ctl_q[1]) & ~wmask) | (wdata & wmask));
        default:    ris_d = ris_q;
      endcase
    end
    // channel 1 has no pin, so its output enable never matters
    ctl_d[1].pin_oe = 1'b0; // RULE7
    // new events win over a same-cycle clear
    ris_d   = ris_d | irq_ev; // RULE12
    irq_d   = |(ris_d & inten_d); // RULE12
    for (int i = 0; i < NUM_CHAN; i++)
      sel_d[i] = decode_src(i, ctl_d[i].src);
    pin_d   = val[0] ^ ctl_q[0].invert; // RULE9
    // software keeps the shared pin to one use; we only drive when told (RULE8)
    oe_d    = ctl_q[0].pin_oe; // RULE7
    trig_d  = trig_ev; // RULE9
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        ctl_q[i] <= '0;
        sel_q[i] <= SRC_OWN_POS;
      end
      ref_q    <= '0;
      ris_q    <= '0;
      inten_q  <= '0;
      irq_q    <= 1'b0;
      pin_q    <= 1'b0;
      oe_q     <= 1'b0;
      trig_q   <= '0;
      awrdy_q  <= 1'b0;
      arrdy_q  <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end
    else
    begin
      ctl_q    <= ctl_d;
      sel_q    <= sel_d;
      ref_q    <= ref_d;
      ris_q    <= ris_d;
      inten_q  <= inten_d;
      irq_q    <= irq_d;
      pin_q    <= pin_d;
      oe_q     <= oe_d;
      trig_q   <= trig_d;
      awrdy_q  <= awrdy_d;
      arrdy_q  <= arrdy_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      bresp_q  <= bresp_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  assign awready                = awrdy_q;
  assign wready                 = awrdy_q;
  assign bvalid                 = bvalid_q;
  assign bresp                  = bresp_q;
  assign arready                = arrdy_q;
  assign rvalid                 = rvalid_q;
  assign rresp                  = rresp_q;
  assign rdata                  = rdata_q;
  assign positive_source_select = sel_q;
  assign reference_control_reg  = ref_q;
  assign comp_zero_out_pin      = pin_q;
  assign comp_zero_out_oe       = oe_q;
  assign adc_trigger            = trig_q;
  assign irq                    = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_irq_masked;
    irq == |(ris_q & inten_q);
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq not raw and enable"); // RULE12

  property p_w1c_clear;
    wr_go && awaddr == OFS_MIS && wstrb[0] && wdata[0] && inten_q[0] && !irq_ev[0]
      |=> !ris_q[0];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("masked status not cleared"); // RULE11

  property p_event_sets;
    irq_ev[1] |=> ris_q[1] ##0 irq == inten_q[1] || irq;
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event lost"); // RULE3

  property p_src0_ref;
    wr_go && awaddr == OFS_CTL0 && &wstrb[1:0] && wdata[CTL_SRC +: 2] == SRC_CODE_R
      |=> ##1 positive_source_select[0] == SRC_REF;
  endproperty
  a_src0_ref: assert property (p_src0_ref) else $error("channel 0 ref select wrong"); // RULE4

  property p_src1_map;
    ctl_q[1].src == SRC_CODE_A |=> positive_source_select[1] == SRC_SHARED_PIN
      || $past(ctl_d[1].src) != SRC_CODE_A;
  endproperty
  a_src1_map: assert property (p_src1_map) else $error("channel 1 shared select wrong"); // RULE5

  property p_pin_follows;
    ##1 comp_zero_out_pin == ($past(val[0]) ^ $past(ctl_q[0].invert));
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("pin not result"); // RULE9

  property p_trig_gate;
    adc_trigger[0] |-> $past(ctl_q[0].trig_en, 2);
  endproperty
  a_trig_gate: assert property (p_trig_gate) else $error("trigger while disabled"); // RULE3

  property p_write_answer;
    wr_go |=> bvalid [*1] ##0 (bresp == (reg_known($past(awaddr)) ? RESP_OKAY : RESP_SLVERR));
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("bad write response"); // RULE10

  property p_read_answer;
    rd_go |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("missing read response"); // RULE10

  c_irq: cover property (irq_ev[0] ##1 irq);
  c_trig: cover property (adc_trigger[1]);
  c_clear: cover property (wr_go && awaddr == OFS_MIS ##1 !irq);
endmodule

`default_nettype wire

/* File: comp_analog.sv */
// analog side model: positive source muxes, the two comparators, channel 0 adc trigger counting
// assumes 8-bit voltage codes from the bench; equal voltages are never applied
`default_nettype none

module comp_analog
  import comp_pkg::*;
(
  // clock
  input  wire logic        aclk,
  // from the block
  input  wire pos_src_type sel [NUM_CHAN],
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  input  wire logic [1:0]  adc_trigger,
  // voltages
  input  wire logic [7:0]  v_pos0,
  input  wire logic [7:0]  v_neg0,
  input  wire logic [7:0]  v_shared,
  input  wire logic [7:0]  v_neg1,
  input  wire logic [7:0]  v_ref,
  // results
  output logic [1:0]       compare_result,
  output logic [7:0]       trig_cnt0,
  output logic             conflict
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] pin_v;
  logic [7:0] pos [2];

  // reserved codes leave the positive input at ground, not a helpful value
  always_comb
  begin
    pin_v = pin_oe ? {8{pin_out}} : v_shared;
    pos[0] = (sel[0] == SRC_OWN_POS) ? v_pos0 : (sel[0] == SRC_REF) ? v_ref : 8'h00;
    case (sel[1])
      SRC_SHARED_PIN: pos[1] = pin_v;
      SRC_ZERO_POS:   pos[1] = v_pos0;
      SRC_REF:        pos[1] = v_ref;
      default:        pos[1] = 8'h00;
    endcase
    compare_result[0] = v_neg0 < pos[0];
    compare_result[1] = v_neg1 < pos[1];
  end

  initial trig_cnt0 = 8'h00;
  initial conflict = 1'b0;

  always @(posedge aclk)
  begin
    if (adc_trigger[0])
      trig_cnt0 <= trig_cnt0 + 8'h01;
    // sticky: pin used as output and as channel 1 input at once
    if (pin_oe && sel[1] == SRC_SHARED_PIN)
      conflict <= 1'b1;
  end
endmodule

`default_nettype wire

/* File: test_dual_comparator_control.sv */
// self-checking bench for comp_ctrl over AXI4-Lite with the analog side model
// assumes comp_ctrl answers every bus request within a few cycles; 100 MHz clock
`default_nettype none

module test_dual_comparator_control;
  import comp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pin, oe, irq, conflict;
  logic [7:0]  awaddr, araddr, v_pos0, v_neg0, v_shared, v_neg1, v_ref, trig_cnt0, t0;
  logic [7:0]  t1, trig_cnt1;
  logic [31:0] wdata, rdata, rd_q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp_q, compare_result, adc_trigger;
  pos_src_type pss [NUM_CHAN];
  ref_ctl_type refc;
  int          num_errors, checks_done;
  pos_src_type e0 [4] = '{SRC_OWN_POS, SRC_OWN_POS, SRC_REF, SRC_NONE};
  pos_src_type e1 [4] = '{SRC_SHARED_PIN, SRC_ZERO_POS, SRC_REF, SRC_NONE};
  logic [7:0]  ofs [8] = '{OFS_MIS, OFS_RIS, OFS_INTEN, OFS_REFCTL,
                           OFS_STAT0, OFS_CTL0, OFS_STAT1, OFS_CTL1};

  comp_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .compare_result(compare_result), .positive_source_select(pss),
    .reference_control_reg(refc), .comp_zero_out_pin(pin), .comp_zero_out_oe(oe),
    .adc_trigger(adc_trigger), .irq(irq));

  comp_analog u_analog (.aclk(aclk), .sel(pss), .pin_out(pin), .pin_oe(oe),
    .adc_trigger(adc_trigger), .v_pos0(v_pos0), .v_neg0(v_neg0), .v_shared(v_shared),
    .v_neg1(v_neg1), .v_ref(v_ref), .compare_result(compare_result),
    .trig_cnt0(trig_cnt0), .conflict(conflict));

  // channel 1 trigger pulses, counted here since the model only counts channel 0
  always @(posedge aclk)
    if (adc_trigger[1])
      trig_cnt1 <= trig_cnt1 + 8'h01;

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // each bus task ends one edge after lowering its ready, so re-entry never collides
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp_q = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_q = rdata;
    resp_q = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk("register read", rd_q, exp);
  endtask

  task automatic stat(input logic [31:0] s0, input logic [31:0] s1);
    repeat (6) @(posedge aclk);
    rchk(OFS_STAT0, s0);
    rchk(OFS_STAT1, s1);
  endtask

  task automatic t_reset;
    // reset control is level sense at level 0, so low results set both raw bits
    for (int i = 0; i < 8; i++)
      rchk(ofs[i], (ofs[i] == OFS_RIS) ? 32'h3 : 32'h0);
    chk("source sel 0", 32'(pss[0]), 32'(SRC_OWN_POS));
    chk("irq", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_bus;
    wr(8'h0C, 32'hFFFFFFFF, 4'hF);
    chk("unmapped bresp", {30'h0, resp_q}, {30'h0, RESP_SLVERR});
    rd(8'h0C);
    chk("unmapped rresp", {30'h0, resp_q}, {30'h0, RESP_SLVERR});
    chk("unmapped rdata", rd_q, 32'h0);
    wr(OFS_REFCTL, 32'h0000030C, 4'h1);
    rchk(OFS_REFCTL, 32'h0000000C);
    wr(OFS_REFCTL, 32'h0000030C, 4'hF);
    chk("write bresp", {30'h0, resp_q}, {30'h0, RESP_OKAY});
    chk("reference ctl", {26'h0, refc}, 32'h0000003C);
  endtask

  // channel 1 code 00 only while the pin output is off
  task automatic t_src;
    for (int c = 0; c < 4; c++)
    begin
      wr(OFS_CTL0, 32'(c) << CTL_SRC, 4'hF);
      wr(OFS_CTL1, 32'(c) << CTL_SRC, 4'hF);
      chk("source sel 0", 32'(pss[0]), 32'(e0[c]));
      chk("source sel 1", 32'(pss[1]), 32'(e1[c]));
    end
  endtask

  task automatic t_cmp;
    wr(OFS_CTL0, 32'h0, 4'hF);
    wr(OFS_CTL1, 32'h1 << CTL_SRC, 4'hF);
    v_neg0 <= 8'h40;
    v_neg1 <= 8'hC0;
    stat(32'h2, 32'h0);
    v_neg0 <= 8'hC0;
    v_neg1 <= 8'h40;
    stat(32'h0, 32'h2);
    wr(OFS_CTL1, 32'h2 << CTL_SRC, 4'hF);
    stat(32'h0, 32'h0);
  endtask

  task automatic t_pin;
    v_neg0 <= 8'h40;
    wr(OFS_CTL0, 32'h1 << CTL_OEN, 4'hF);
    stat(32'h2, 32'h0);
    chk("pin enable", {31'h0, oe}, 32'h1);
    chk("pin level", {31'h0, pin}, 32'h1);
    wr(OFS_CTL0, (32'h1 << CTL_OEN) | (32'h1 << CTL_INV), 4'hF);
    stat(32'h2, 32'h0);
    chk("pin inverted", {31'h0, pin}, 32'h0);
    wr(OFS_CTL1, (32'h1 << CTL_OEN) | (32'h1 << CTL_SRC), 4'hF);
    rchk(OFS_CTL1, 32'h1 << CTL_SRC);
  endtask

  task automatic t_evt;
    wr(OFS_CTL0, (32'h2 << CTL_ISEN) | (32'h1 << CTL_TSEN) | (32'h1 << CTL_TEN), 4'hF);
    wr(OFS_CTL1, (32'h2 << CTL_ISEN) | (32'h3 << CTL_TSEN) | (32'h1 << CTL_TEN) |
       (32'h1 << CTL_SRC), 4'hF);
    v_neg0 <= 8'hC0;
    v_neg1 <= 8'hC0;
    stat(32'h0, 32'h0);
    wr(OFS_INTEN, 32'h3, 4'hF);
    wr(OFS_MIS, 32'h3, 4'hF);
    rchk(OFS_RIS, 32'h0);
    t0 = trig_cnt0;
    v_neg0 <= 8'h40;
    stat(32'h2, 32'h0);
    rchk(OFS_RIS, 32'h1);
    chk("no trigger on rise", {24'h0, trig_cnt0}, {24'h0, t0});
    chk("irq", {31'h0, irq}, 32'h1);
    rchk(OFS_MIS, 32'h1);
    v_neg0 <= 8'hC0;
    stat(32'h0, 32'h0);
    chk("trigger on fall", {24'h0, trig_cnt0}, {24'h0, t0 + 8'h01});
    wr(OFS_MIS, 32'h1, 4'hF);
    rchk(OFS_RIS, 32'h0);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(OFS_INTEN, 32'h2, 4'hF);
    v_neg0 <= 8'h40;
    stat(32'h2, 32'h0);
    rchk(OFS_RIS, 32'h1);
    rchk(OFS_MIS, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    t1 = trig_cnt1;
    v_neg1 <= 8'h40;
    stat(32'h2, 32'h2);
    rchk(OFS_RIS, 32'h3);
    rchk(OFS_MIS, 32'h2);
    chk("irq channel 1", {31'h0, irq}, 32'h1);
    v_neg1 <= 8'hC0;
    stat(32'h2, 32'h0);
    chk("trigger both edges", {24'h0, trig_cnt1}, {24'h0, t1 + 8'h02});
    chk("pin conflict", {31'h0, conflict}, 32'h0);
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    complete_run();
  end

  initial
  begin
    num_errors = 0;
    checks_done = 0;
    trig_cnt1 = 8'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    v_pos0 = 8'h80;
    v_neg0 = 8'hC0;
    v_shared = 8'h10;
    v_neg1 = 8'hC0;
    v_ref = 8'h20;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_bus();
    t_src();
    t_cmp();
    t_pin();
    t_evt();
    complete_run();
  end
endmodule

`default_nettype wire
